// file: vscm_pkg.sv
// Constants, register map and types of the valve solenoid command mapper.
// Assumes a 25 MHz system clock and a 10-bit converter sharing that clock.
`default_nettype none
package vscm_pkg;
	// ****************************************************
	// Widths and timing
	// ****************************************************
	localparam int ADC_W = 10;
	localparam int CLK_HZ = 25_000_000;
	localparam int PWM_HZ = 1000;
	localparam int PWM_CYC = CLK_HZ / PWM_HZ;
	localparam int PWM_W = $clog2(PWM_CYC);
	localparam int CB_TIME_MS = 100;
	localparam int CB_CYC = (CLK_HZ / 1000) * CB_TIME_MS;
	localparam int FULL_UA = 20000;
	localparam int CB_UA = 3000;
	localparam int LZ_UA = 4000;
	localparam int CODE_MAX = 1023;
	localparam logic [9:0] CB_THRESH = 10'(CB_UA * CODE_MAX / FULL_UA);
	localparam logic [9:0] LIVE_ZERO = 10'(LZ_UA * CODE_MAX / FULL_UA);
	localparam logic [9:0] CODE_FULL = 10'(CODE_MAX);
	localparam logic [14:0] PWM_LAST = 15'(PWM_CYC - 1);

	// ****************************************************
	// Register map
	// ****************************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CFG = 8'h04;
	localparam logic [7:0] A_IMIN_A = 8'h08;
	localparam logic [7:0] A_IMAX_A = 8'h0C;
	localparam logic [7:0] A_IMIN_B = 8'h10;
	localparam logic [7:0] A_IMAX_B = 8'h14;
	localparam logic [7:0] A_WINDOW = 8'h18;
	localparam logic [7:0] A_DITHER = 8'h1C;
	localparam logic [7:0] A_HOST_CMD = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;
	localparam logic [7:0] A_CMD_VAL = 8'h28;
	localparam logic [7:0] A_FB_VAL = 8'h2C;

	// ****************************************************
	// Modes
	// ****************************************************
	typedef enum logic [3:0] {
		CM_PQ_OL = 4'h3,
		CM_PQ_CL = 4'h4,
		CM_POS_OL = 4'h6,
		CM_SPD_CL = 4'h7,
		CM_POS_CL = 4'h9,
		CM_PRS_CL = 4'hB
	} vscm_cmode_e;
	typedef enum logic [2:0] {
		MO_UNI1 = 3'h1,
		MO_UNI2 = 3'h2,
		MO_BIP = 3'h3,
		MO_TOG = 3'h5
	} vscm_mop_e;
	typedef enum logic [1:0] {
		DO_FUNC = 2'h0,
		DO_LO = 2'h1,
		DO_HI = 2'h2
	} vscm_do_e;
	typedef enum logic {
		ST_OFF = 1'b0,
		ST_ACT = 1'b1
	} vscm_state_e;

	// ****************************************************
	// Register layouts
	// ****************************************************
	typedef struct packed {
		logic host_din2;
		logic host_en;
		logic remote;
		logic [2:0] mode_op;
		logic [3:0] cmode;
	} vscm_ctrl_s;
	typedef struct packed {
		logic [1:0] do2_cfg;
		logic [1:0] do1_cfg;
		logic cb_en;
		logic fb_420;
		logic cmd_420;
	} vscm_cfg_s;
	typedef struct packed {
		logic [9:0] imax;
		logic [9:0] imin;
	} vscm_chan_s;
	localparam vscm_ctrl_s CTRL_RST = '{host_din2: 1'b0, host_en: 1'b0, remote: 1'b0,
		mode_op: 3'h1, cmode: 4'h3};
	localparam vscm_cfg_s CFG_RST = '{do2_cfg: 2'h0, do1_cfg: 2'h0, cb_en: 1'b0,
		fb_420: 1'b0, cmd_420: 1'b0};
	localparam vscm_chan_s CHAN_RST = '{imax: 10'h3FF, imin: 10'h000};
endpackage
`default_nettype wire

// file: vscm_core.sv
// Control core of a proportional valve amplifier: input scaling, cable fault,
// enable, mode mapping, PWM solenoid drive with dither and digital outputs.
// Assumes converter samples arrive on clk; pins din1, din2, two_sol are async.
// Summary of operation
// - Each analogue input is taken as a 10-bit converter code.
// - Current input below 3 mA with fault check on blocks solenoids, raises error.
// - Cable fault is declared after the low signal persists about 100 ms.
// - Digital input 1 is active-high enable; disabled means no solenoid current.
// - Host enable bit replaces the pin enable in host-controlled operation.
// - Mode of operation 5 drives A with input 2 low, B with it high.
// - Each solenoid output is 1000 Hz PWM with superimposed dither.
// - Digital output 1 shows error or a fixed 0 or 1.
// - Open-loop modes 3 and 6: digital output 2 shows solenoid B active.
// - Closed-loop modes 4, 7, 9: digital output 2 shows target window reached.
// - Digital output 2 can be forced to a fixed 0 or 1.
// - Mode 3 runs open loop; solenoids follow mode of operation.
// - Mode 4 closes loop on driver 1 only, ignoring mode of operation.
// - Mode 6 runs spool valve open loop; solenoids follow mode of operation.
// - Mode 7 closes speed loop on both drivers, ignoring mode of operation.
// - Mode 9 closes position loop on both drivers, ignoring mode of operation.
// - Pressure mode: driver 1 loads, driver 2 unloads, mode of operation ignored.
// - Mode of operation matters only in open-loop controller modes.
// - Mode of operation 1 maps 0-100 percent onto solenoid A range.
// - Mode 2: lower half to B falling, upper half to A rising.
// - Mode 3 bipolar: negative to B falling, positive to A rising.
// - Modes 2, 3, 5 need two-solenoid unit; mode 1 single-solenoid unit.
// - Local or host operation may change only while disabled.
`timescale 1ns/1ps
`default_nettype none
module vscm_core
	import vscm_pkg::*;
#(
	parameter int CB_CYCLES = CB_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Converter samples, channel 0 command, channel 1 feedback
	input wire logic adc_valid,
	input wire logic adc_chan,
	input wire logic [ADC_W-1:0] adc_code,
	// Pins
	input wire logic din1,
	input wire logic din2,
	input wire logic two_sol,
	// Outputs
	output logic sol_a_pwm,
	output logic sol_b_pwm,
	output logic do1,
	output logic do2
);
	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	logic [2:0] pin_m_q;
	logic [2:0] pin_s_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_m_q <= 3'h0;
			pin_s_q <= 3'h0;
		end else begin
			pin_m_q <= {two_sol, din2, din1};
			pin_s_q <= pin_m_q;
		end
	end
	wire logic din1_s = pin_s_q[0];
	wire logic din2_s = pin_s_q[1];
	wire logic two_s = pin_s_q[2];

	// ****************************************************
	// Registers
	// ****************************************************
	vscm_ctrl_s ctrl_q;
	vscm_cfg_s cfg_q;
	vscm_chan_s chan_q [2];
	logic [9:0] window_q;
	logic [7:0] dither_q;
	logic [9:0] host_cmd_q;
	vscm_state_e state_q;
	vscm_ctrl_s ctrl_w;
	wire logic wr_ctrl = reg_wr && (reg_addr == A_CTRL);
	wire logic remote_d = (state_q == ST_OFF) ? ctrl_w.remote : ctrl_q.remote;
	always_comb begin
		ctrl_w = vscm_ctrl_s'(reg_wdata[9:0]);
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_q <= CTRL_RST;
			cfg_q <= CFG_RST;
			window_q <= 10'h000;
			dither_q <= 8'h00;
			host_cmd_q <= 10'h000;
		end else if (reg_wr) begin
			if (wr_ctrl) begin
				ctrl_q <= '{host_din2: ctrl_w.host_din2, host_en: ctrl_w.host_en, remote: remote_d,
					mode_op: ctrl_w.mode_op, cmode: ctrl_w.cmode};
			end
			if (reg_addr == A_CFG) begin
				cfg_q <= vscm_cfg_s'(reg_wdata[6:0]);
			end
			if (reg_addr == A_WINDOW) begin
				window_q <= reg_wdata[9:0];
			end
			if (reg_addr == A_DITHER) begin
				dither_q <= reg_wdata[7:0];
			end
			if (reg_addr == A_HOST_CMD) begin
				host_cmd_q <= reg_wdata[9:0];
			end
		end
	end

	// ****************************************************
	// Converter capture and cable fault, per input
	// ****************************************************
	localparam int CBW = $clog2(CB_CYCLES + 1);
	logic [9:0] raw_q [2];
	logic [1:0] fault_q;
	logic [1:0] range_420;
	assign range_420 = {cfg_q.fb_420, cfg_q.cmd_420};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_in
			logic [CBW-1:0] cb_cnt_q;
			wire logic low = range_420[gi] && cfg_q.cb_en && (raw_q[gi] < CB_THRESH);
			always_ff @(posedge clk) begin
				if (!nrst) begin
					raw_q[gi] <= 10'h000;
				end else if (adc_valid && (adc_chan == gi[0])) begin
					raw_q[gi] <= adc_code;
				end
			end
			always_ff @(posedge clk) begin
				if (!nrst || !low) begin
					cb_cnt_q <= '0;
					fault_q[gi] <= 1'b0;
				end else if (cb_cnt_q == CBW'(CB_CYCLES - 1)) begin
					fault_q[gi] <= 1'b1;
				end else begin
					cb_cnt_q <= cb_cnt_q + CBW'(1);
				end
			end
		end
	endgenerate
	wire logic fault = |fault_q;

	// ****************************************************
	// Input scaling
	// ****************************************************
	function automatic logic [9:0] scale420(input logic [9:0] raw);
		logic [10:0] t;
		logic [11:0] s;
		t = {1'b0, raw} - {1'b0, LIVE_ZERO};
		s = {1'b0, t} + {3'h0, t[10:2]};
		if (raw <= LIVE_ZERO) begin
			scale420 = 10'h000;
		end else if (s > {2'h0, CODE_FULL}) begin
			scale420 = CODE_FULL;
		end else begin
			scale420 = s[9:0];
		end
	endfunction
	wire logic [9:0] cmd_loc = cfg_q.cmd_420 ? scale420(raw_q[0]) : raw_q[0];
	wire logic [9:0] cmd_n = ctrl_q.remote ? host_cmd_q : cmd_loc;
	wire logic [9:0] fb_n = cfg_q.fb_420 ? scale420(raw_q[1]) : raw_q[1];
	wire logic sel_b_in = ctrl_q.remote ? ctrl_q.host_din2 : din2_s;

	// ****************************************************
	// Enable state
	// ****************************************************
	// host or pin enable
	wire logic en_eff = ctrl_q.remote ? ctrl_q.host_en : din1_s;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= en_eff ? ST_ACT : ST_OFF;
		end
	end
	wire logic run = (state_q == ST_ACT) && !fault;

	// ****************************************************
	// Mode mapping
	// ****************************************************
	wire logic [10:0] err = {1'b0, cmd_n} - {1'b0, fb_n};
	wire logic err_neg = err[10];
	wire logic [10:0] err_abs = err_neg ? (11'h000 - err) : err;
	wire logic [9:0] mag = err_abs[9:0];
	wire logic in_win = mag <= window_q;
	wire logic [9:0] up_half = {cmd_n[8:0], 1'b0};
	wire logic [9:0] dn_half = {~cmd_n[8:0], 1'b0};
	logic on_a;
	logic on_b;
	logic [9:0] lvl_a;
	logic [9:0] lvl_b;
	logic open_loop;
	logic closed_loop;
	always_comb begin
		on_a = 1'b0;
		on_b = 1'b0;
		lvl_a = 10'h000;
		lvl_b = 10'h000;
		open_loop = 1'b0;
		closed_loop = 1'b0;
		unique case (ctrl_q.cmode)
			// mode of operation used here only
			CM_PQ_OL, CM_POS_OL: begin
				open_loop = 1'b1;
				unique case (ctrl_q.mode_op)
					MO_UNI1: begin
						on_a = !two_s;
						lvl_a = cmd_n;
					end
					MO_UNI2, MO_BIP: begin
						on_a = two_s && cmd_n[9];
						on_b = two_s && !cmd_n[9];
						lvl_a = up_half;
						lvl_b = dn_half;
					end
					MO_TOG: begin
						on_a = two_s && !sel_b_in;
						on_b = two_s && sel_b_in;
						lvl_a = cmd_n;
						lvl_b = cmd_n;
					end
					default: begin
					end
				endcase
			end
			CM_PQ_CL: begin
				closed_loop = 1'b1;
				on_a = !err_neg;
				lvl_a = mag;
			end
			CM_SPD_CL, CM_POS_CL: begin
				closed_loop = 1'b1;
				on_a = !err_neg;
				on_b = err_neg;
				lvl_a = mag;
				lvl_b = mag;
			end
			CM_PRS_CL: begin
				on_a = !err_neg;
				on_b = err_neg;
				lvl_a = mag;
				lvl_b = mag;
			end
			default: begin
			end
		endcase
	end

	// ****************************************************
	// PWM period and dither phase
	// ****************************************************
	logic [14:0] pwm_cnt_q;
	logic dith_q;
	wire logic pwm_wrap = (pwm_cnt_q == PWM_LAST);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwm_cnt_q <= 15'h0000;
			dith_q <= 1'b0;
		end else if (pwm_wrap) begin
			pwm_cnt_q <= 15'h0000;
			dith_q <= !dith_q;
		end else begin
			pwm_cnt_q <= pwm_cnt_q + 15'h0001;
		end
	end

	// ****************************************************
	// Solenoid channels
	// ****************************************************
	logic [1:0] on_c;
	logic [9:0] lvl_c [2];
	logic [1:0] pwm_q;
	assign on_c = {on_b, on_a};
	assign lvl_c[0] = lvl_a;
	assign lvl_c[1] = lvl_b;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sol
			logic [14:0] duty_q;
			wire logic [9:0] span = (chan_q[gi].imax > chan_q[gi].imin) ?
				(chan_q[gi].imax - chan_q[gi].imin) : 10'h000;
			wire logic [19:0] prod = 20'(span) * 20'(lvl_c[gi]);
			wire logic [9:0] sp = chan_q[gi].imin + prod[19:10];
			wire logic [10:0] sp_up = {1'b0, sp} + {3'h0, dither_q};
			wire logic [10:0] sp_dn = {1'b0, sp} - {3'h0, dither_q};
			wire logic [9:0] sp_hi = sp_up[10] ? CODE_FULL : sp_up[9:0];
			wire logic [9:0] sp_lo = sp_dn[10] ? 10'h000 : sp_dn[9:0];
			wire logic [9:0] sp_d = dith_q ? sp_hi : sp_lo;
			wire logic [24:0] duty_p = 25'(sp_d) * 25'(PWM_CYC);
			wire logic chan_on = run && on_c[gi];
			always_ff @(posedge clk) begin
				if (!nrst) begin
					chan_q[gi] <= CHAN_RST;
				end else if (reg_wr && (reg_addr == (gi[0] ? A_IMIN_B : A_IMIN_A))) begin
					chan_q[gi].imin <= reg_wdata[9:0];
				end else if (reg_wr && (reg_addr == (gi[0] ? A_IMAX_B : A_IMAX_A))) begin
					chan_q[gi].imax <= reg_wdata[9:0];
				end
			end
			always_ff @(posedge clk) begin
				if (!nrst) begin
					duty_q <= 15'h0000;
					pwm_q[gi] <= 1'b0;
				end else begin
					if (pwm_wrap) begin
						duty_q <= duty_p[24:10];
					end
					pwm_q[gi] <= chan_on && (pwm_cnt_q < duty_q);
				end
			end
		end
	endgenerate
	assign sol_a_pwm = pwm_q[0];
	assign sol_b_pwm = pwm_q[1];

	// ****************************************************
	// Digital outputs
	// ****************************************************
	wire logic sol_b_act = run && on_b;
	wire logic do2_fn = (open_loop && sol_b_act) || (closed_loop && run && in_win);
	logic do1_q;
	logic do2_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			do1_q <= 1'b0;
			do2_q <= 1'b0;
		end else begin
			unique case (cfg_q.do1_cfg)
				DO_FUNC: do1_q <= fault;
				DO_LO: do1_q <= 1'b0;
				DO_HI: do1_q <= 1'b1;
				default: do1_q <= fault;
			endcase
			unique case (cfg_q.do2_cfg)
				DO_FUNC: do2_q <= do2_fn;
				DO_LO: do2_q <= 1'b0;
				DO_HI: do2_q <= 1'b1;
				default: do2_q <= do2_fn;
			endcase
		end
	end
	assign do1 = do1_q;
	assign do2 = do2_q;

	// ****************************************************
	// Read port
	// ****************************************************
	logic [31:0] rmux;
	logic [31:0] rdata_q;
	always_comb begin
		unique case (reg_addr)
			A_CTRL: rmux = {22'h000000, ctrl_q};
			A_CFG: rmux = {25'h0000000, cfg_q};
			A_IMIN_A: rmux = {22'h000000, chan_q[0].imin};
			A_IMAX_A: rmux = {22'h000000, chan_q[0].imax};
			A_IMIN_B: rmux = {22'h000000, chan_q[1].imin};
			A_IMAX_B: rmux = {22'h000000, chan_q[1].imax};
			A_WINDOW: rmux = {22'h000000, window_q};
			A_DITHER: rmux = {24'h000000, dither_q};
			A_HOST_CMD: rmux = {22'h000000, host_cmd_q};
			A_STATUS: rmux = {26'h0000000, ctrl_q.remote, two_s, in_win, sol_b_act, fault,
				state_q == ST_ACT};
			A_CMD_VAL: rmux = {22'h000000, raw_q[0]};
			A_FB_VAL: rmux = {22'h000000, raw_q[1]};
			default: rmux = 32'h00000000;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= reg_rd ? rmux : 32'h00000000;
		end
	end
	assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// file: vscm_core_sva.sv
// Port-level checker for the valve solenoid command mapper core.
// Assumes it is bound to vscm_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module vscm_core_sva
	import vscm_pkg::*;
#(
	parameter int CB_CYCLES = CB_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Converter samples
	input wire logic adc_valid,
	input wire logic adc_chan,
	input wire logic [ADC_W-1:0] adc_code,
	// Pins and outputs
	input wire logic din1,
	input wire logic din2,
	input wire logic two_sol,
	input wire logic sol_a_pwm,
	input wire logic sol_b_pwm,
	input wire logic do1,
	input wire logic do2
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ********
	// Shadows of configuration, command and pulse length
	// ********
	logic [6:0] cfg_q;
	logic [9:0] cmd_q;
	logic seen_q;
	logic [15:0] hi_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= 7'h00;
			cmd_q <= 10'h000;
			seen_q <= 1'b0;
			hi_q <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == A_CFG) begin
				cfg_q <= reg_wdata[6:0];
			end
			if (adc_valid && !adc_chan) begin
				cmd_q <= adc_code;
				seen_q <= 1'b1;
			end
			hi_q <= sol_a_pwm ? hi_q + 16'h0001 : 16'h0000;
		end
	end
	// ********
	// Assertions
	// ********
	a_sol_exclusive: assert property (!(sol_a_pwm && sol_b_pwm))
		else $error("both solenoid outputs driven");
	a_pwm_width: assert property (hi_q < 16'(PWM_CYC))
		else $error("solenoid pulse longer than one period");
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read answer");
	a_rd_unmapped: assert property ($past(reg_rd) && $past(reg_addr) > 8'h2C |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_rd_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[31:10] == 22'h0)
		else $error("upper read bits not zero");
	a_twosol_seen: assert property ($past(reg_rd) && $past(reg_addr) == A_STATUS && $past(two_sol, 5) == two_sol
		&& $past(two_sol, 3) == two_sol && $past(two_sol) == two_sol |-> reg_rdata[4] == two_sol)
		else $error("unit strap not shown in status");
	a_cmd_raw: assert property ($past(reg_rd && reg_addr == A_CMD_VAL && !(adc_valid && !adc_chan))
		&& $past(seen_q) |-> reg_rdata[9:0] == $past(cmd_q))
		else $error("command code read back wrong");
	a_do1_fixed: assert property (cfg_q[4:3] inside {2'h1, 2'h2} && $stable(cfg_q) |-> do1 == cfg_q[4])
		else $error("fixed level of output 1 wrong");
	a_do2_fixed: assert property (cfg_q[6:5] inside {2'h1, 2'h2} && $stable(cfg_q) |-> do2 == cfg_q[6])
		else $error("fixed level of output 2 wrong");
	a_fault_blocks: assert property (cfg_q[4:3] == 2'h0 && $stable(cfg_q) && do1 |-> !sol_a_pwm && !sol_b_pwm)
		else $error("solenoid driven while error shown");
endmodule
bind vscm_core vscm_core_sva #(.CB_CYCLES(CB_CYCLES)) i_vscm_core_sva (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
	.adc_chan(adc_chan), .adc_code(adc_code), .din1(din1), .din2(din2), .two_sol(two_sol),
	.sol_a_pwm(sol_a_pwm), .sol_b_pwm(sol_b_pwm), .do1(do1), .do2(do2));
`default_nettype wire

// file: vscm_sensor_model.sv
// Converter model for command source and feedback sensor.
// Assumes the core samples on the same clock; alternates channels every 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module vscm_sensor_model
	import vscm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Analogue levels
	input wire logic [ADC_W-1:0] cmd_code,
	input wire logic [ADC_W-1:0] fb_code,
	// Sample stream
	output logic adc_valid,
	output logic adc_chan,
	output logic [ADC_W-1:0] adc_code
);
	logic [1:0] slot_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			slot_q <= 2'h0;
			adc_valid <= 1'b0;
			adc_chan <= 1'b0;
			adc_code <= 10'h000;
		end else begin
			slot_q <= slot_q + 2'h1;
			adc_valid <= (slot_q == 2'h3);
			if (slot_q == 2'h3) begin
				adc_chan <= ~adc_chan;
				adc_code <= adc_chan ? cmd_code : fb_code;
			end else begin
				adc_code <= ~adc_code;
			end
		end
	end
endmodule
`default_nettype wire

// file: test_valve_solenoid_command_mapper.sv
// Self-checking bench for the valve solenoid command mapper core.
// Assumes a 25 MHz clock and the converter model on the sample port.
`timescale 1ns/1ps
`default_nettype none
module test_valve_solenoid_command_mapper;
	import vscm_pkg::*;
	localparam int CBN = 20;
	logic clk, nrst, reg_wr, reg_rd, din1, din2, two_sol;
	logic adc_valid, adc_chan, sol_a_pwm, sol_b_pwm, do1, do2;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [9:0] adc_code, cmd_code, fb_code;
	int fail_count, n_tests, seed_r, v, w, n, d;
	logic [9:0] vals[6];
	logic [3:0] cms[4];

	vscm_core #(.CB_CYCLES(CBN)) i_vscm_core (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_chan(adc_chan),
		.adc_code(adc_code), .din1(din1), .din2(din2), .two_sol(two_sol), .sol_a_pwm(sol_a_pwm),
		.sol_b_pwm(sol_b_pwm), .do1(do1), .do2(do2));
	vscm_sensor_model i_vscm_sensor_model (.clk(clk), .nrst(nrst), .cmd_code(cmd_code), .fb_code(fb_code),
		.adc_valid(adc_valid), .adc_chan(adc_chan), .adc_code(adc_code));

	// ********
	// Tasks
	// ********
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(string what, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(what, reg_rdata & m, exp);
	endtask
	task automatic look(int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wait_a(logic lvl, output int k);
		k = 0;
		while (sol_a_pwm !== lvl && k < 30000) begin
			@(negedge clk);
			k++;
		end
	endtask
	function automatic logic in_win(int c, int f, int win);
		return ((c > f) ? c - f : f - c) <= win;
	endfunction
	function automatic int pwm_high(int c, int d);
		return ((((CODE_MAX * c) >> 10) + d) * PWM_CYC) >> 10;
	endfunction
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ********
	// Clock, watchdog and tests
	// ********
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		results();
	end
	initial begin
		{nrst, reg_wr, reg_rd, din1, din2, two_sol} = 6'h01;
		{reg_addr, reg_wdata, cmd_code, fb_code} = '0;
		seed_r = $urandom(32'h3EF5ED36);
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rchk("ctrl reset", A_CTRL, 32'hFFFFFFFF, 32'(CTRL_RST));
		rchk("imax reset", A_IMAX_B, 32'hFFFFFFFF, 32'h3FF);
		rchk("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
		check("do1 idle", 32'(do1), 32'h0);
		wr(A_CTRL, 32'h193);
		look(5);
		rchk("host enable", A_STATUS, 32'h21, 32'h21);
		wr(A_CTRL, 32'h353);
		look(4);
		check("host sel b", 32'(do2), 32'h1);
		wr(A_CTRL, 32'h013);
		rchk("remote locked", A_STATUS, 32'h21, 32'h20);
		wr(A_CTRL, 32'h093);
		look(3);
		wr(A_CTRL, 32'h003);
		rchk("remote freed", A_STATUS, 32'h21, 32'h0);
		// Toggled solenoid selection by input 2
		wr(A_CTRL, 32'h053);
		two_sol <= 1'b1;
		din1 <= 1'b1;
		repeat (6) begin
			@(posedge clk);
			din2 <= 1'($urandom);
			cmd_code <= 10'($urandom);
			look(10);
			check("do2 sol b", 32'(do2), 32'(din2));
			rchk("sol b status", A_STATUS, 32'h5, {29'h0, din2, 2'h1});
		end
		@(posedge clk);
		din1 <= 1'b0;
		look(6);
		check("do2 disabled", 32'(do2), 32'h0);
		@(posedge clk);
		din1 <= 1'b1;
		// Split and bipolar mapping, centre corners
		vals = '{10'h000, 10'h1FF, 10'h200, 10'h3FF, 10'($urandom), 10'($urandom)};
		for (int m = 2; m <= 3; m++) begin
			wr(A_CTRL, 32'(m << 4) | ((m == 3) ? 32'h6 : 32'h3));
			foreach (vals[i]) begin
				cmd_code <= vals[i];
				look(12);
				check("do2 split", 32'(do2), 32'(vals[i] < 10'h200));
				@(posedge clk);
			end
		end
		// Closed loop target window, mode of operation left invalid
		cms = '{4'h4, 4'h7, 4'h9, 4'hB};
		foreach (cms[i]) begin
			repeat (3) begin
				v = 100 + $urandom % 800;
				w = $urandom % 16;
				wr(A_CTRL, 32'(cms[i]));
				wr(A_WINDOW, 32'(w));
				cmd_code <= 10'(v);
				fb_code <= 10'(v + $urandom % 41 - 20);
				look(20);
				check("do2 window", 32'(do2), 32'(cms[i] != 4'hB && in_win(v, int'(fb_code), w)));
			end
		end
		for (int c = 1; c <= 2; c++) begin
			wr(A_CFG, 32'((c << 5) | (c << 3)));
			look(4);
			check("do1 fixed", 32'(do1), 32'(c == 2));
			check("do2 fixed", 32'(do2), 32'(c == 2));
		end
		// Broken current loop on the command input
		wr(A_CTRL, 32'h053);
		cmd_code <= 10'h064;
		look(12);
		wr(A_CFG, 32'h05);
		look(CBN - 2);
		check("fault early", 32'(do1), 32'h0);
		look(3);
		check("fault do1", 32'(do1), 32'h1);
		rchk("fault status", A_STATUS, 32'h2, 32'h2);
		@(posedge clk);
		cmd_code <= 10'h258;
		look(20);
		check("fault clear", 32'(do1), 32'h0);
		// Single solenoid PWM duty
		wr(A_CFG, 32'h0);
		two_sol <= 1'b0;
		v = 100 + $urandom % 800;
		d = 1 + $urandom % 64;
		wr(A_DITHER, 32'(d));
		wr(A_CTRL, 32'h013);
		cmd_code <= 10'(v);
		look(12);
		rchk("cmd raw", A_CMD_VAL, 32'h3FF, 32'(v));
		wait_a(1'b0, n);
		wait_a(1'b1, n);
		wait_a(1'b0, w);
		wait_a(1'b1, n);
		wait_a(1'b0, n);
		check("pwm high", 32'(w + n), 32'(pwm_high(v, d) + pwm_high(v, -d)));
		check("pwm dither", 32'(w > n ? w - n : n - w), 32'(pwm_high(v, d) - pwm_high(v, -d)));
		results();
	end
endmodule
`default_nettype wire
